// ===== hdl/css_peer.sv
`timescale 1ns/1ps
`default_nettype none
module css_peer
  import css_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  css_link_if.peer link,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata
);
  logic go_ff;
  logic master_ff;
  logic [7:0] div_ff;
  logic done_ff;
  logic [7:0] shift_ff;
  logic [3:0] bit_cnt_ff;
  logic [7:0] half_cnt_ff;
  logic sclk_ff;
  logic out_ff;
  logic ck_s1_ff;
  logic ck_s2_ff;
  logic ck_s3_ff;
  logic ck_lvl_ff;
  logic rx_s1_ff;
  logic rx_s2_ff;
  logic rx_s3_ff;
  logic dp_wr_ff;
  logic [7:0] dp_addr_ff;
  logic [31:0] rdata_ff;

  // address phase capture, zero wait states
  wire ap_take = hsel & htrans[1] & hready;
  wire wr_ctl = dp_wr_ff & (dp_addr_ff == CSS_POFS_CTRL);
  wire wr_data = dp_wr_ff & (dp_addr_ff == CSS_POFS_DATA);
  wire rd_data = ap_take & ~hwrite & (haddr[7:0] == CSS_POFS_DATA);

  // own clock as master, synced pin edges as follower
  wire half_tick = go_ff & master_ff & (half_cnt_ff == div_ff - 8'h01);
  wire ck_agree = (ck_s2_ff == ck_s3_ff);
  wire ck_change = go_ff & ~master_ff & ck_agree & (ck_s3_ff != ck_lvl_ff);
  wire fall_ev = master_ff ? (half_tick & sclk_ff) : (ck_change & ~ck_s3_ff);
  wire rise_ev = master_ff ? (half_tick & ~sclk_ff) : (ck_change & ck_s3_ff);
  wire last_bit = rise_ev & (bit_cnt_ff == 4'(CSS_BITS - 1));
  wire nxt_done = last_bit | (done_ff & ~(rd_data | wr_data)); // R20

  // ahb-lite bus state
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dp_wr_ff <= 1'b0;
      dp_addr_ff <= 8'h00;
    end else begin
      dp_wr_ff <= ap_take & hwrite & (hsize == 3'h2);
      dp_addr_ff <= haddr[7:0];
    end
  end

  // control registers; write wins over self clear
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      go_ff <= 1'b0;
      master_ff <= 1'b0;
      div_ff <= CSS_PDIV_RST;
      done_ff <= 1'b0;
    end else begin
      done_ff <= nxt_done;
      if (wr_ctl) begin
        go_ff <= hwdata[CSS_PB_GO]; // R14 R15
        master_ff <= hwdata[CSS_PB_MASTER]; // R3
        div_ff <= hwdata[CSS_PB_DIV_LSB +: 8];
      end else if (last_bit) begin
        go_ff <= 1'b0;
      end
    end
  end

  // shift engine timing
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      half_cnt_ff <= 8'h00;
      bit_cnt_ff <= 4'h0;
      sclk_ff <= 1'b1;
      out_ff <= 1'b1;
    end else if (!go_ff) begin
      half_cnt_ff <= 8'h00;
      bit_cnt_ff <= 4'h0;
      sclk_ff <= 1'b1;
      out_ff <= 1'b1;
    end else begin
      half_cnt_ff <= (half_tick | ~master_ff) ? 8'h00 : half_cnt_ff + 8'h01;
      if (half_tick) begin
        sclk_ff <= ~sclk_ff;
      end
      if (rise_ev) begin
        bit_cnt_ff <= bit_cnt_ff + 4'h1;
      end
      if (fall_ev) begin
        out_ff <= shift_ff[0]; // R22
      end
    end
  end

  // data register, lsb first
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      shift_ff <= 8'h00;
    end else if (wr_data) begin
      shift_ff <= hwdata[7:0];
    end else if (rise_ev) begin
      shift_ff <= {rx_s3_ff, shift_ff[7:1]}; // R22
    end
  end

  // pin synchronisers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ck_s1_ff <= 1'b1;
      ck_s2_ff <= 1'b1;
      ck_s3_ff <= 1'b1;
      ck_lvl_ff <= 1'b1;
      rx_s1_ff <= 1'b1;
      rx_s2_ff <= 1'b1;
      rx_s3_ff <= 1'b1;
    end else begin
      ck_s1_ff <= link.sclk;
      ck_s2_ff <= ck_s1_ff;
      ck_s3_ff <= ck_s2_ff;
      ck_lvl_ff <= ck_agree ? ck_s3_ff : ck_lvl_ff;
      rx_s1_ff <= link.dev_txd;
      rx_s2_ff <= rx_s1_ff;
      rx_s3_ff <= rx_s2_ff;
    end
  end

  // read mux, captured at the address phase
  wire [31:0] ctl_view = {16'h0000, div_ff, 6'h00, master_ff, go_ff};
  wire [31:0] stat_view = {30'h00000000, done_ff, go_ff};
  wire [7:0] ra = haddr[7:0];
  wire [31:0] rd_mux = (ra == CSS_POFS_CTRL) ? ctl_view :
                       (ra == CSS_POFS_DATA) ? {24'h000000, shift_ff} :
                       (ra == CSS_POFS_STAT) ? stat_view : 32'h00000000;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rdata_ff <= 32'h00000000;
    end else if (ap_take & ~hwrite) begin
      rdata_ff <= rd_mux;
    end
  end

  // outputs
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = rdata_ff;
  assign link.sclk_peer_oe = master_ff; // R6
  assign link.sclk_peer_o = sclk_ff;
  assign link.peer_txd = out_ff;
endmodule : css_peer
`default_nettype wire

// ===== hdl/css_port.sv
// Added by the designer: register access over io_wr/io_rd strobes.
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// R1: tx_go set starts transmit, enables clock
// R2: internal rate drives clock out when enabled
// R3: external rate takes clock pin as input
// R4: transmit shifts data out on serial_out_pin
// R5: after 8 bits clear tx_go, set done_flag
// R6: tx_go and rx_go never both one
// R7: tx_go cleared on reset and io_halt_mode
// R8: rate_sel three bits, reset to external
// R9: codes divide by 20 up to 1280
// R10: clock pin output only for internal rates
// R11: one data register for both directions
// R12: data write during transmit replaces shift data
// R13: software avoids data reads while busy
// R14: polled transmit: wait, write, set tx_go
// R15: receive: wait, set rx_go, wait, read
// R16: software idles port before changing rate
// R17: clearing a go bit aborts at once
// R18: reset aborts, data register kept
// R19: rx_go shifts 8 bits in, then done
// R20: done_flag cleared on data access, halt
// R21: irq while done_flag and done_irq_en
// R22: lsb first, drive fall, sample rise
module css_port
  import css_pkg::*;
#(
  parameter int DIV_BASE = CSS_DIV_BASE
) (
  input wire logic hclk,
  input wire logic hresetn,
  css_link_if.dev link,
  input wire logic [7:0] io_addr,
  input wire logic [7:0] io_wdata,
  input wire logic io_wr,
  input wire logic io_rd,
  input wire logic io_halt_mode,
  output logic [7:0] io_rdata,
  output logic irq
);
  localparam int HALF = DIV_BASE / 2;
  localparam int CW = $clog2(HALF * 64) + 1;

  logic tx_go_ff;
  logic rx_go_ff;
  logic done_ff;
  logic irq_en_ff;
  logic [2:0] rate_ff;
  logic [7:0] shift_ff;
  logic [3:0] bit_cnt_ff;
  logic [CW-1:0] half_cnt_ff;
  logic sclk_int_ff;
  logic out_ff;
  logic [7:0] rdata_ff;
  logic ck_s1_ff;
  logic ck_s2_ff;
  logic ck_s3_ff;
  logic ck_lvl_ff;
  logic rx_s1_ff;
  logic rx_s2_ff;
  logic rx_s3_ff;

  // register decode
  wire wr_ctl = io_wr & (io_addr == CSS_OFS_CTRL);
  wire wr_data = io_wr & (io_addr == CSS_OFS_DATA);
  wire rd_ctl = io_rd & (io_addr == CSS_OFS_CTRL);
  wire rd_data = io_rd & (io_addr == CSS_OFS_DATA);
  wire busy = tx_go_ff | rx_go_ff;
  wire ext_mode = (rate_ff == CSS_RATE_EXT);

  // internal bit clock, half period scaled by rate code
  wire [CW-1:0] half_len = CW'(HALF) << rate_ff; // R9
  wire half_tick = busy & ~ext_mode & (half_cnt_ff == half_len - CW'(1));
  wire int_fall = half_tick & sclk_int_ff;
  wire int_rise = half_tick & ~sclk_int_ff;

  // external clock edges once the last two sync stages agree
  wire ck_agree = (ck_s2_ff == ck_s3_ff);
  wire ck_change = ck_agree & (ck_s3_ff != ck_lvl_ff);
  wire ext_fall = busy & ext_mode & ck_change & ~ck_s3_ff; // R3
  wire ext_rise = busy & ext_mode & ck_change & ck_s3_ff; // R3

  // one edge source, chosen by rate_sel
  wire fall_ev = ext_mode ? ext_fall : int_fall;
  wire rise_ev = ext_mode ? ext_rise : int_rise;
  wire last_bit = rise_ev & (bit_cnt_ff == 4'(CSS_BITS - 1));

  // go bits as written, receive has priority on a double set
  wire rx_req = io_wdata[CSS_BIT_RX_GO] & ~tx_go_ff; // R6
  wire tx_req = io_wdata[CSS_BIT_TX_GO] & ~rx_go_ff & ~io_wdata[CSS_BIT_RX_GO]; // R6

  logic nxt_tx_go;
  logic nxt_rx_go;
  // go bit update: halt, software write, self clear at end
  always_comb begin
    nxt_tx_go = tx_go_ff;
    nxt_rx_go = rx_go_ff;
    if (io_halt_mode) begin
      nxt_tx_go = 1'b0; // R7
      nxt_rx_go = 1'b0;
    end else if (wr_ctl) begin
      nxt_tx_go = tx_req; // R1 R17
      nxt_rx_go = rx_req; // R17 R19
    end else if (last_bit) begin
      nxt_tx_go = 1'b0; // R5
      nxt_rx_go = 1'b0; // R19
    end
  end

  // completion flag, a finishing bit wins over an access clear
  wire nxt_done = io_halt_mode ? 1'b0 :
                  (last_bit | (done_ff & ~(rd_data | wr_data))); // R5 R19 R20

  // control and status registers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tx_go_ff <= 1'b0; // R7 R18
      rx_go_ff <= 1'b0; // R18
      done_ff <= 1'b0; // R20
      irq_en_ff <= 1'b0; // R21
      rate_ff <= CSS_RATE_RST; // R8
    end else begin
      tx_go_ff <= nxt_tx_go;
      rx_go_ff <= nxt_rx_go;
      done_ff <= nxt_done;
      if (wr_ctl) begin
        irq_en_ff <= io_wdata[CSS_BIT_IRQ_EN];
        rate_ff <= io_wdata[CSS_RATE_LSB +: 3]; // R8
      end
    end
  end

  // divider, bit counter and internal clock level
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      half_cnt_ff <= '0;
      bit_cnt_ff <= 4'h0;
      sclk_int_ff <= 1'b1;
    end else if (!busy) begin
      half_cnt_ff <= '0; // R17
      bit_cnt_ff <= 4'h0;
      sclk_int_ff <= 1'b1;
    end else begin
      half_cnt_ff <= (half_tick | ext_mode) ? '0 : half_cnt_ff + CW'(1);
      if (half_tick) begin
        sclk_int_ff <= ~sclk_int_ff; // R1 R2
      end
      if (rise_ev) begin
        bit_cnt_ff <= bit_cnt_ff + 4'h1;
      end
    end
  end

  // serial output changes on falling edges, idles high
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      out_ff <= 1'b1;
    end else if (!tx_go_ff) begin
      out_ff <= 1'b1;
    end else if (fall_ev) begin
      out_ff <= shift_ff[0]; // R4 R22
    end
  end

  // shared data register, no reset so contents survive one
  always_ff @(posedge hclk) begin
    if (wr_data) begin
      shift_ff <= io_wdata; // R11 R12
    end else if (rise_ev) begin
      shift_ff <= {rx_s3_ff, shift_ff[7:1]}; // R11 R19 R22
    end
  end

  // pin synchronisers for clock and data input
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ck_s1_ff <= 1'b1;
      ck_s2_ff <= 1'b1;
      ck_s3_ff <= 1'b1;
      ck_lvl_ff <= 1'b1;
      rx_s1_ff <= 1'b1;
      rx_s2_ff <= 1'b1;
      rx_s3_ff <= 1'b1;
    end else begin
      ck_s1_ff <= link.sclk;
      ck_s2_ff <= ck_s1_ff;
      ck_s3_ff <= ck_s2_ff;
      ck_lvl_ff <= ck_agree ? ck_s3_ff : ck_lvl_ff;
      rx_s1_ff <= link.peer_txd;
      rx_s2_ff <= rx_s1_ff;
      rx_s3_ff <= rx_s2_ff;
    end
  end

  // read data, live shift contents while busy
  wire [7:0] ctl_view = {done_ff, irq_en_ff, rx_go_ff, tx_go_ff, 1'b0, rate_ff};
  wire [7:0] rd_mux = rd_ctl ? ctl_view : (rd_data ? shift_ff : 8'h00); // R13

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rdata_ff <= CSS_RDATA_RST;
    end else if (io_rd) begin
      rdata_ff <= rd_mux;
    end
  end

  // outputs
  assign io_rdata = rdata_ff;
  assign irq = done_ff & irq_en_ff; // R21
  assign link.sclk_dev_oe = ~ext_mode; // R2 R3 R10
  assign link.sclk_dev_o = sclk_int_ff; // R10
  assign link.dev_txd = out_ff; // R4
endmodule : css_port
`default_nettype wire

// ===== inc/css_link_if.sv
`timescale 1ns/1ps
`default_nettype none
interface css_link_if;
  logic sclk_dev_o;
  logic sclk_dev_oe;
  logic sclk_peer_o;
  logic sclk_peer_oe;
  logic dev_txd;
  logic peer_txd;
  logic sclk;
  // resolved clock pin, pulled high when nobody drives
  assign sclk = sclk_dev_oe ? sclk_dev_o : (sclk_peer_oe ? sclk_peer_o : 1'b1);
  modport dev (
    output sclk_dev_o,
    output sclk_dev_oe,
    output dev_txd,
    input sclk,
    input peer_txd
  );
  modport peer (
    output sclk_peer_o,
    output sclk_peer_oe,
    output peer_txd,
    input sclk,
    input dev_txd
  );
endinterface : css_link_if
`default_nettype wire

// ===== inc/css_pkg.sv
`default_nettype none
package css_pkg;
  // port-side register offsets
  localparam logic [7:0] CSS_OFS_CTRL = 8'h0a;
  localparam logic [7:0] CSS_OFS_DATA = 8'h0b;
  // control field positions
  localparam int CSS_BIT_DONE = 7;
  localparam int CSS_BIT_IRQ_EN = 6;
  localparam int CSS_BIT_RX_GO = 5;
  localparam int CSS_BIT_TX_GO = 4;
  localparam int CSS_RATE_LSB = 0;
  // rate codes and reset values
  localparam logic [2:0] CSS_RATE_EXT = 3'h7;
  localparam logic [2:0] CSS_RATE_RST = 3'h7;
  localparam logic [7:0] CSS_RDATA_RST = 8'h00;
  // timing counts in system clocks, and bits per frame
  localparam int CSS_DIV_BASE = 20;
  localparam int CSS_BITS = 8;
  // peer-side register offsets over ahb-lite
  localparam logic [7:0] CSS_POFS_CTRL = 8'h00;
  localparam logic [7:0] CSS_POFS_DATA = 8'h04;
  localparam logic [7:0] CSS_POFS_STAT = 8'h08;
  localparam int CSS_PB_GO = 0;
  localparam int CSS_PB_MASTER = 1;
  localparam int CSS_PB_DIV_LSB = 8;
  localparam int CSS_PB_BUSY = 0;
  localparam int CSS_PB_DONE = 1;
  localparam logic [7:0] CSS_PDIV_RST = 8'h0a;
endpackage : css_pkg
`default_nettype wire

// ===== tb/clocked_sync_serial_port_tb.sv
`timescale 1ns/1ps
`default_nettype none
module clocked_sync_serial_port_tb;
  import css_pkg::*;
  localparam int DIVB = 4;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic [7:0] io_addr = 8'h0;
  logic [7:0] io_wdata = 8'h0;
  logic io_wr = 1'b0;
  logic io_rd = 1'b0;
  logic io_halt_mode = 1'b0;
  logic [7:0] io_rdata;
  logic irq;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic hreadyout;
  logic hresp;
  logic [31:0] hrdata;
  wire hready = hreadyout;
  int error_cnt = 0;
  int checks_done = 0;
  css_link_if link();
  css_port #(.DIV_BASE(DIVB)) u_css_port (.hclk(hclk), .hresetn(hresetn), .link(link),
    .io_addr(io_addr), .io_wdata(io_wdata), .io_wr(io_wr), .io_rd(io_rd),
    .io_halt_mode(io_halt_mode), .io_rdata(io_rdata), .irq(irq));
  css_peer u_css_peer (.hclk(hclk), .hresetn(hresetn), .link(link), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata));
  css_link_checker #(.DIV_BASE(DIVB)) u_css_link_checker (.hclk(hclk), .hresetn(hresetn),
    .sclk_dev_o(link.sclk_dev_o), .sclk_dev_oe(link.sclk_dev_oe),
    .sclk_peer_oe(link.sclk_peer_oe), .dev_txd(link.dev_txd));
  // system clock
  initial begin
    forever #2 hclk = ~hclk;
  end
  task automatic stop_test();
    $display("errors %0d checks %0d", error_cnt, checks_done);
    if (error_cnt == 0 && checks_done > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : stop_test
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic tmo();
    error_cnt++;
    $display("mismatch at %0t got %h exp %h", $time, 1'b0, 1'b1);
    stop_test();
  endtask : tmo
  // device port access, data settled at the falling edge
  task automatic io(input logic rd, input logic [7:0] a, input logic [7:0] d,
                    output logic [7:0] q);
    @(posedge hclk);
    io_addr <= a;
    io_wdata <= d;
    io_wr <= !rd;
    io_rd <= rd;
    @(posedge hclk);
    io_wr <= 1'b0;
    io_rd <= 1'b0;
    @(negedge hclk);
    q = io_rdata;
  endtask : io
  task automatic rdy();
    for (int i = 0; i < 50; i++) begin
      @(posedge hclk);
      if (hreadyout === 1'b1) return;
    end
    tmo();
  endtask : rdy
  task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= wr;
    rdy();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    rdy();
    q = hrdata;
  endtask : ahb
  // poll control until the masked go bit drops
  task automatic poll(input logic [7:0] m, output logic [7:0] q);
    for (int i = 0; i < 4000; i++) begin
      io(1'b1, CSS_OFS_CTRL, 8'h0, q);
      if ((q & m) === 8'h0) return;
    end
    tmo();
  endtask : poll
  // poll peer status until its busy bit drops
  task automatic pwait();
    logic [31:0] w;
    for (int i = 0; i < 200; i++) begin
      ahb(1'b0, CSS_POFS_STAT, 32'h0, w);
      if (w[CSS_PB_BUSY] === 1'b0) return;
    end
    tmo();
  endtask : pwait
  task automatic t_rates();
    logic [7:0] q;
    logic [7:0] b;
    logic [7:0] ie;
    logic [31:0] w;
    int n;
    for (int r = 0; r < 7; r++) begin
      b = 8'h96 + 8'(r);
      ie = (r == 0) ? 8'h40 : 8'h00;
      ahb(1'b1, CSS_POFS_CTRL, 32'h0801, w);
      io(1'b0, CSS_OFS_DATA, b, q);
      io(1'b0, CSS_OFS_CTRL, 8'h10 | ie | 8'(r), q);
      n = 0;
      while (link.sclk !== 1'b0) begin
        @(negedge hclk);
        n++;
        if (n > 2000) tmo();
      end
      n = 0;
      while (link.sclk !== 1'b1) begin
        @(negedge hclk);
        n++;
        if (n > 2000) tmo();
      end
      chk(32'(n), 32'((DIVB / 2) << r));
      poll(8'h10, q);
      chk({24'h0, q}, {24'h0, 8'h80 | ie | 8'(r)});
      chk({31'h0, irq}, {31'h0, ie[6]});
      pwait();
      ahb(1'b0, CSS_POFS_DATA, 32'h0, w);
      chk({24'h0, w[7:0]}, {24'h0, b});
      io(1'b1, CSS_OFS_DATA, 8'h0, q);
      io(1'b1, CSS_OFS_CTRL, 8'h0, q);
      chk({24'h0, q}, {24'h0, ie | 8'(r)});
      chk({31'h0, irq}, 32'h0);
      // idle past one slow bit time and the checker's frame gap
      repeat (400) @(posedge hclk);
    end
    io(1'b0, CSS_OFS_CTRL, 8'h07, q);
  endtask : t_rates
  task automatic t_ext();
    logic [7:0] q;
    logic [31:0] w;
    io(1'b0, CSS_OFS_CTRL, 8'h37, q);
    io(1'b1, CSS_OFS_CTRL, 8'h0, q);
    chk({24'h0, q}, 32'h27);
    ahb(1'b1, CSS_POFS_DATA, 32'hc5, w);
    ahb(1'b1, CSS_POFS_CTRL, 32'h0803, w);
    poll(8'h20, q);
    chk({24'h0, q}, 32'h87);
    io(1'b1, CSS_OFS_DATA, 8'h0, q);
    chk({24'h0, q}, 32'hc5);
    // transmit timed by the peer's clock
    io(1'b0, CSS_OFS_DATA, 8'ha3, q);
    io(1'b0, CSS_OFS_CTRL, 8'h17, q);
    ahb(1'b1, CSS_POFS_CTRL, 32'h0803, w);
    poll(8'h10, q);
    chk({24'h0, q}, 32'h87);
    pwait();
    ahb(1'b0, CSS_POFS_DATA, 32'h0, w);
    chk({24'h0, w[7:0]}, 32'ha3);
    io(1'b1, CSS_OFS_DATA, 8'h0, q);
    io(1'b0, CSS_OFS_CTRL, 8'h27, q);
    io(1'b0, CSS_OFS_CTRL, 8'h07, q);
    ahb(1'b1, CSS_POFS_CTRL, 32'h0803, w);
    repeat (4) @(posedge hclk);
    pwait();
    io(1'b1, CSS_OFS_CTRL, 8'h0, q);
    chk({24'h0, q}, 32'h07);
  endtask : t_ext
  task automatic t_halt_reset();
    logic [7:0] q;
    io(1'b0, CSS_OFS_CTRL, 8'h17, q);
    io(1'b0, CSS_OFS_DATA, 8'h3c, q);
    @(posedge hclk);
    io_halt_mode <= 1'b1;
    @(posedge hclk);
    io_halt_mode <= 1'b0;
    io(1'b1, CSS_OFS_CTRL, 8'h0, q);
    chk({24'h0, q}, 32'h07);
    io(1'b1, CSS_OFS_DATA, 8'h0, q);
    chk({24'h0, q}, 32'h3c);
    io(1'b0, CSS_OFS_DATA, 8'h5a, q);
    io(1'b0, CSS_OFS_CTRL, 8'h67, q);
    @(posedge hclk);
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    io(1'b1, CSS_OFS_CTRL, 8'h0, q);
    chk({24'h0, q}, 32'h07);
    io(1'b1, CSS_OFS_DATA, 8'h0, q);
    chk({24'h0, q}, 32'h5a);
  endtask : t_halt_reset
  // main sequence
  initial begin
    logic [7:0] q;
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    io(1'b1, CSS_OFS_CTRL, 8'h0, q);
    chk({24'h0, q}, 32'h07);
    chk({31'h0, irq}, 32'h0);
    t_rates();
    t_ext();
    t_halt_reset();
    stop_test();
  end
endmodule : clocked_sync_serial_port_tb
`default_nettype wire

// ===== tb/css_link_checker.sv
`timescale 1ns/1ps
`default_nettype none
module css_link_checker #(
  parameter int DIV_BASE = 20
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic sclk_dev_o,
  input wire logic sclk_dev_oe,
  input wire logic sclk_peer_oe,
  input wire logic dev_txd
);
  localparam int HMIN = DIV_BASE / 2;
  localparam int HMAX = HMIN << 6;
  localparam int GAP = 3 * HMAX;
  logic prv_ff;
  logic [15:0] cnt_ff;
  logic [3:0] falls_ff;
  // clock edge decode
  wire edge_w = sclk_dev_o != prv_ff;
  wire fall_w = edge_w && !sclk_dev_o;
  // cycles since last clock edge, falls per frame
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      prv_ff <= 1'b1;
      cnt_ff <= 16'hffff;
      falls_ff <= 4'h0;
    end else begin
      prv_ff <= sclk_dev_o;
      cnt_ff <= edge_w ? 16'h0 : ((cnt_ff == 16'hffff) ? cnt_ff : cnt_ff + 16'h1);
      falls_ff <= (cnt_ff == 16'(GAP)) ? 4'h0 : falls_ff + 4'(fall_w);
    end
  end
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  sequence s_dev_fall;
    sclk_dev_oe && fall_w;
  endsequence
  sequence s_in_frame;
    sclk_dev_oe && falls_ff != 4'h0 && falls_ff != 4'h8;
  endsequence
  a_min_half: assert property (sclk_dev_oe && edge_w |-> cnt_ff >= 16'(HMIN - 1))
    else $error("clock half period too short");
  a_max_half: assert property (s_in_frame |-> cnt_ff < 16'(HMAX))
    else $error("clock half period too long");
  a_eight_falls: assert property (s_dev_fall |-> falls_ff < 4'h8)
    else $error("more than eight bits in a frame");
  a_idle_high: assert property (cnt_ff == 16'(GAP) |-> sclk_dev_o)
    else $error("clock not idle high");
  a_txd_on_rise: assert property (sclk_dev_oe && edge_w && sclk_dev_o |-> $stable(dev_txd))
    else $error("data changed on rising edge");
  a_txd_hold: assert property (s_dev_fall |=> $stable(dev_txd))
    else $error("data not held after falling edge");
  a_one_driver: assert property (!(sclk_dev_oe && sclk_peer_oe))
    else $error("both ends drive the clock");
  a_oe_idle: assert property ($changed(sclk_dev_oe) |-> sclk_dev_o && $past(sclk_dev_o))
    else $error("clock direction changed mid cycle");
endmodule : css_link_checker
`default_nettype wire
